//--- src/ufc_defines.vh
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH
// Register byte offsets
`define UFC_OFF_CTL      5'h00
`define UFC_OFF_RXD      5'h04
`define UFC_OFF_TXD      5'h08
`define UFC_OFF_STA      5'h0c
`define UFC_OFF_BR       5'h10
`define UFC_OFF_IMASK    5'h14
`define UFC_OFF_DMACNT   5'h18
// Control field positions
`define UFC_CTL_RXON     31
`define UFC_CTL_TXON     30
`define UFC_CTL_DBG_HI   25
`define UFC_CTL_DBG_LO   24
`define UFC_CTL_TXFEN    23
`define UFC_CTL_RXFEN    22
`define UFC_CTL_TXCLK    21
`define UFC_CTL_LOOP     20
`define UFC_CTL_TX_INTERRUPT_ON     19
`define UFC_CTL_RX_INTERRUPT_ON     18
`define UFC_CTL_TX_DMA_REQUEST_ON     17
`define UFC_CTL_RX_DMA_REQUEST_ON     16
`define UFC_CTL_EN       15
`define UFC_CTL_RXCLK    14
`define UFC_CTL_SRTS     13
`define UFC_CTL_AFE      12
`define UFC_CTL_RTH_HI   11
`define UFC_CTL_RTH_LO   10
`define UFC_CTL_TTH_HI   9
`define UFC_CTL_TTH_LO   8
`define UFC_CTL_CTSC     7
`define UFC_CTL_PEN      6
`define UFC_CTL_STK      5
`define UFC_CTL_EPS      4
`define UFC_CTL_STOP     2
`define UFC_CTL_WID_HI   1
`define UFC_CTL_WID_LO   0
// Writable control bits mask (29:26 and 3 reserved)
`define UFC_CTL_MASK     32'hc3fffff7
// Status field positions
`define UFC_STA_PAER     23
`define UFC_STA_STER     22
`define UFC_STA_BUSY     21
`define UFC_STA_TXFL_LO  16
`define UFC_STA_RXFL_LO  11
`define UFC_STA_RXIRQ    1
`define UFC_STA_TXIRQ    0
// Reset values, FIFO depth and timing constants
`define UFC_RST_CTL      32'h00000000
`define UFC_RST_BR       16'h0000
`define UFC_FIFO_DEPTH   5'h10
`define UFC_RX_PERIOD_NS 166
`define UFC_CLK_NS       20
`define UFC_LINE_MIN_CYC (`UFC_RX_PERIOD_NS / `UFC_CLK_NS)
`endif

//--- src/ufc_uart.v
// Overview of operation
// [R1] Frames carry 5 to 8 data bits LSB first plus one or two stops.
// [R2] Parity is even, odd or none, same setting for both directions.
// [R3] Separate sixteen byte FIFOs buffer transmit and receive characters.
// [R4] Line rates up to six megabits per second are supported.
// [R5] Auto flow bit 12 lets hardware drive RTS and honour CTS.
// [R6] Bit 23 enables transmit FIFO, bit 22 receive FIFO.
// [R7] Bits 21 and 14 pick bus or DMA clock for each FIFO; here both bits are stored only and both FIFOs run on pclk.
// [R8] Loopback bit 20 routes transmit output into receive input.
// [R9] Loopback with auto flow also routes RTS back onto CTS.
// [R10] Receive threshold 00 requests at one byte; enables bits 19..16.
// [R11] Without auto flow bit 13 drives RTS; zero asserts it.
// [R12] A receive DMA counter counts bytes delivered to memory.
// [R13] Block idles unless enabled; bits 31 and 30 gate each path.
// [R14] Transmit threshold bits 9:8 request at 1, 4, 8 or 12 free.
// [R15] CTS check bit 7 samples CTS before each character.
// [R16] Stop select bit 2 gives one or two transmitted stop bits.
// [R17] Width field 1:0 encodes five through eight data bits.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "ufc_defines.vh"
module ufc_uart (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [4:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Serial pins, active-low handshakes
  input  wire        rxd,
  input  wire        cts_n,
  output reg         txd,
  output reg         rts_n,
  // Requests
  output reg         irq,
  output reg         tx_drq,
  output reg         rx_drq
);
  // ==========================================================
  // Registers and pin synchronisers
  reg [31:0] ctl_q;
  reg [15:0] br_q;
  reg [1:0]  imask_q;
  reg [1:0]  pst_q;
  reg [15:0] dmacnt_q;
  reg [1:0]  rx_s_q;
  reg [1:0]  cts_s_q;
  reg [7:0]  txm [0:15];
  reg [7:0]  rxm [0:15];
  reg [4:0]  tcnt_q, rcnt_q;
  reg [3:0]  twp_q, trp_q, rwp_q, rrp_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s_q  <= 2'h3;
      cts_s_q <= 2'h3;
    end else begin
      rx_s_q  <= {rx_s_q[0], rxd};
      cts_s_q <= {cts_s_q[0], cts_n};
    end
  end
  wire en      = ctl_q[`UFC_CTL_EN];
  wire tx_on   = en & ctl_q[`UFC_CTL_TXON];                        // R13
  wire rx_on   = en & ctl_q[`UFC_CTL_RXON];                        // R13
  wire afe     = ctl_q[`UFC_CTL_AFE];
  wire loop    = ctl_q[`UFC_CTL_LOOP];
  wire [3:0] nbits = {2'h0, ctl_q[`UFC_CTL_WID_HI:`UFC_CTL_WID_LO]} + 4'h5; // R17
  wire pen     = ctl_q[`UFC_CTL_PEN];
  // Parity bit: stick forces a constant, else even/odd over data    // R2
  function par_of(input [7:0] d, input [3:0] n, input stk, input eps);
    reg [7:0] m;
    begin
      m = d & ~(8'hff << n);
      if (stk)
        par_of = ~eps;
      else
        par_of = (^m) ^ ~eps;
    end
  endfunction
  // RTS: hardware asserts while receive FIFO holds fewer than fourteen bytes when auto flow
  // Withdrawing at fourteen leaves two bytes of room for a late sender
  wire rts_d = afe ? (rcnt_q >= 5'h0e) : ctl_q[`UFC_CTL_SRTS];     // R5 R11
  wire rx_line = loop ? txd : rx_s_q[1];                           // R8
  wire cts_line = (loop && afe) ? rts_n : cts_s_q[1];              // R9
  wire cts_gate = (afe | ctl_q[`UFC_CTL_CTSC]) ? ~cts_line : 1'b1; // R5 R15
  // ==========================================================
  // APB decode
  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire rd    = acc & ~pwrite;
  // Unaligned or out-of-range offsets answer with pslverr
  wire known = (paddr <= `UFC_OFF_DMACNT) && (paddr[1:0] == 2'h0);
  wire txf_en = ctl_q[`UFC_CTL_TXFEN];
  wire rxf_en = ctl_q[`UFC_CTL_RXFEN];
  // With a FIFO disabled the store acts as a single holding byte   R6
  wire [4:0] tlim = txf_en ? `UFC_FIFO_DEPTH : 5'h01;              // R6
  wire [4:0] rlim = rxf_en ? `UFC_FIFO_DEPTH : 5'h01;              // R6
  wire tx_push = wr && paddr == `UFC_OFF_TXD && tcnt_q < tlim;
  wire rx_pop  = rd && paddr == `UFC_OFF_RXD && rcnt_q != 5'h00;
  // ==========================================================
  // Baud tick: one tick per bit, divisor from baud register        R4
  // A divisor of N gives N+1 clocks per bit; zero runs at full clock
  reg [15:0] bdiv_q;
  wire tick = (bdiv_q == 16'h0000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      bdiv_q <= 16'h0000;
    else if (tick || !en)
      bdiv_q <= br_q;
    else
      bdiv_q <= bdiv_q - 16'h0001;
  end
  // ==========================================================
  // Transmitter
  reg [1:0]  ts_q;
  reg [3:0]  tb_q;
  reg [7:0]  tsh_q;
  reg        tpar_q;
  localparam TS_IDLE = 2'h0, TS_DATA = 2'h1, TS_PAR = 2'h2, TS_STOP = 2'h3;
  // CTS is checked only between characters, never in mid-frame
  wire tx_pop = (ts_q == TS_IDLE) && tick && tx_on && tcnt_q != 5'h00 && cts_gate;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_q   <= TS_IDLE;
      tb_q   <= 4'h0;
      tsh_q  <= 8'h00;
      tpar_q <= 1'b0;
      txd    <= 1'b1;
    end else if (!tx_on) begin
      ts_q <= TS_IDLE;
      txd  <= 1'b1;
    end else if (tick) begin
      case (ts_q)
        TS_IDLE: begin
          if (tx_pop) begin
            tsh_q  <= txm[trp_q];
            tpar_q <= par_of(txm[trp_q], nbits, ctl_q[`UFC_CTL_STK], ctl_q[`UFC_CTL_EPS]);
            tb_q   <= 4'h0;
            txd    <= 1'b0;
            ts_q   <= TS_DATA;
          end
        end
        TS_DATA: begin
          txd   <= tsh_q[0];                                       // R1
          tsh_q <= {1'b0, tsh_q[7:1]};
          tb_q  <= tb_q + 4'h1;
          if (tb_q == nbits - 4'h1)
            ts_q <= pen ? TS_PAR : TS_STOP;
          if (tb_q == nbits - 4'h1)
            tb_q <= 4'h0;
        end
        TS_PAR: begin
          txd  <= tpar_q;                                          // R2
          ts_q <= TS_STOP;
        end
        TS_STOP: begin
          txd  <= 1'b1;
          tb_q <= tb_q + 4'h1;
          if (tb_q == {3'h0, ctl_q[`UFC_CTL_STOP]})                // R16
            ts_q <= TS_IDLE;
        end
        default: ts_q <= TS_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Receiver: samples mid-bit using a one-and-a-half-divisor start delay
  reg [1:0]  rs_q;
  reg [3:0]  rb_q;
  reg [7:0]  rsh_q;
  reg [15:0] rdiv_q;
  reg        rpar_q;
  reg        rpe_q, rse_q;
  localparam RS_IDLE = 2'h0, RS_DATA = 2'h1, RS_PAR = 2'h2, RS_STOP = 2'h3;
  // First sample lands one and a half bits after the start edge
  wire rtick = (rdiv_q == 16'h0000);
  wire rx_push = (rs_q == RS_STOP) && rtick && rcnt_q < rlim;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_q   <= RS_IDLE;
      rb_q   <= 4'h0;
      rsh_q  <= 8'h00;
      rdiv_q <= 16'h0000;
      rpar_q <= 1'b0;
      rpe_q  <= 1'b0;
      rse_q  <= 1'b0;
    end else begin
      // Error strobes last one clock; the sticky status keeps them
      rpe_q <= 1'b0;
      rse_q <= 1'b0;
      if (!rx_on) begin
        rs_q <= RS_IDLE;
      end else if (rs_q == RS_IDLE) begin
        if (!rx_line) begin
          rdiv_q <= br_q + {1'b0, br_q[15:1]};
          rb_q   <= 4'h0;
          rsh_q  <= 8'h00;
          rs_q   <= RS_DATA;
        end
      end else if (!rtick) begin
        rdiv_q <= rdiv_q - 16'h0001;
      end else begin
        rdiv_q <= br_q;
        case (rs_q)
          RS_DATA: begin
            rsh_q <= rsh_q | ({7'h00, rx_line} << rb_q);           // R1
            rb_q  <= rb_q + 4'h1;
            if (rb_q == nbits - 4'h1)
              rs_q <= pen ? RS_PAR : RS_STOP;
          end
          RS_PAR: begin
            rpar_q <= rx_line;
            rpe_q  <= rx_line != par_of(rsh_q, nbits, ctl_q[`UFC_CTL_STK], ctl_q[`UFC_CTL_EPS]); // R2
            rs_q   <= RS_STOP;
          end
          RS_STOP: begin
            rse_q <= ~rx_line;
            rs_q  <= RS_IDLE;
          end
          default: rs_q <= RS_IDLE;
        endcase
      end
    end
  end
  // ==========================================================
  // FIFOs, one clock domain; clock choice bits stored only        R3 R7
  // Storage has no reset; transmit reads wait on the count, but an RXD read returns rxm even when empty
  always @(posedge pclk) begin
    if (tx_push)
      txm[twp_q] <= pwdata[7:0];
    if (rx_push)
      rxm[rwp_q] <= rsh_q;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_q <= 5'h00;
      rcnt_q <= 5'h00;
      twp_q  <= 4'h0;
      trp_q  <= 4'h0;
      rwp_q  <= 4'h0;
      rrp_q  <= 4'h0;
    end else begin
      twp_q  <= twp_q + {3'h0, tx_push};                           // R3
      trp_q  <= trp_q + {3'h0, tx_pop};
      tcnt_q <= tcnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
      rwp_q  <= rwp_q + {3'h0, rx_push};                           // R3
      rrp_q  <= rrp_q + {3'h0, rx_pop};
      rcnt_q <= rcnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end
  // ==========================================================
  // Thresholds
  wire [4:0] tfree = `UFC_FIFO_DEPTH - tcnt_q;
  reg  [4:0] tneed, rneed;
  always @* begin
    case (ctl_q[`UFC_CTL_TTH_HI:`UFC_CTL_TTH_LO])                  // R14
      2'h0:    tneed = 5'h01;
      2'h1:    tneed = 5'h04;
      2'h2:    tneed = 5'h08;
      default: tneed = 5'h0c;
    endcase
    case (ctl_q[`UFC_CTL_RTH_HI:`UFC_CTL_RTH_LO])                  // R10
      2'h0:    rneed = 5'h01;
      2'h1:    rneed = 5'h04;
      2'h2:    rneed = 5'h08;
      default: rneed = 5'h0c;
    endcase
  end
  // Levels, not pulses: they stay up while the condition holds
  wire tx_req = tx_on && tfree >= tneed;
  wire rx_req = rx_on && rcnt_q >= rneed;
  // ==========================================================
  // Register writes, sticky status (set beats clear)
  reg perr_q, serr_q;
  wire w_sta = wr && paddr == `UFC_OFF_STA;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q    <= `UFC_RST_CTL;
      br_q     <= `UFC_RST_BR;
      imask_q  <= 2'h0;
      perr_q   <= 1'b0;
      serr_q   <= 1'b0;
      pst_q    <= 2'h0;
      dmacnt_q <= 16'h0000;
    end else begin
      if (wr && paddr == `UFC_OFF_CTL)
        ctl_q <= pwdata & `UFC_CTL_MASK;
      if (wr && paddr == `UFC_OFF_BR)
        br_q <= pwdata[15:0];
      if (wr && paddr == `UFC_OFF_IMASK)
        imask_q <= pwdata[1:0];
      perr_q <= rpe_q | (perr_q & ~(w_sta & pwdata[`UFC_STA_PAER]));
      serr_q <= rse_q | (serr_q & ~(w_sta & pwdata[`UFC_STA_STER]));
      pst_q[1] <= rx_req | (pst_q[1] & ~(w_sta & pwdata[`UFC_STA_RXIRQ]));
      pst_q[0] <= tx_req | (pst_q[0] & ~(w_sta & pwdata[`UFC_STA_TXIRQ]));
      // Counts pops while receive DMA is enabled; writing clears  R12
      if (rx_pop && ctl_q[`UFC_CTL_RX_DMA_REQUEST_ON])
        dmacnt_q <= dmacnt_q + 16'h0001;                           // R12
      else if (wr && paddr == `UFC_OFF_DMACNT)
        dmacnt_q <= 16'h0000;
    end
  end
  // ==========================================================
  // Read mux and registered outputs
  // Busy until the queue is empty and the last stop bit has started
  wire busy = (tcnt_q != 5'h00) || (ts_q != TS_IDLE);
  // Read data is picked at setup, so a pop cannot shift it mid-access
  reg [31:0] rdat;
  always @* begin
    rdat = 32'h00000000;
    case (paddr)
      `UFC_OFF_CTL:    rdat = ctl_q;
      `UFC_OFF_RXD:    rdat = {24'h000000, rxm[rrp_q]};
      `UFC_OFF_STA:    rdat = {8'h00, perr_q, serr_q, busy, tfree, rcnt_q,
                               9'h000, pst_q};
      `UFC_OFF_BR:     rdat = {16'h0000, br_q};
      `UFC_OFF_IMASK:  rdat = {30'h00000000, imask_q};
      `UFC_OFF_DMACNT: rdat = {16'h0000, dmacnt_q};
      default:         rdat = 32'h00000000;
    endcase
  end
  // Zero-wait APB: pready is held high, read data registered at setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      rts_n   <= 1'b1;
      irq     <= 1'b0;
      tx_drq  <= 1'b0;
      rx_drq  <= 1'b0;
    end else begin
      pready  <= 1'b1;
      prdata  <= (psel && !penable && !pwrite) ? rdat : prdata;
      pslverr <= psel && !penable && !known;
      rts_n   <= en ? rts_d : 1'b1;                                 // R5 R11
      irq     <= |(pst_q & imask_q & {ctl_q[`UFC_CTL_RX_INTERRUPT_ON], ctl_q[`UFC_CTL_TX_INTERRUPT_ON]}); // R10
      tx_drq  <= tx_req & ctl_q[`UFC_CTL_TX_DMA_REQUEST_ON];                    // R14
      rx_drq  <= rx_req & ctl_q[`UFC_CTL_RX_DMA_REQUEST_ON];                    // R10
    end
  end
endmodule
`default_nettype wire

//--- verification/ufc_uart_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checks for the serial block
module ufc_uart_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [4:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and requests
  input wire logic        rxd,
  input wire logic        cts_n,
  input wire logic        txd,
  input wire logic        rts_n,
  input wire logic        irq,
  input wire logic        tx_drq,
  input wire logic        rx_drq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase, and whether its address lies outside the map
  wire logic acc = psel && penable;
  wire logic bad = paddr > 5'h18 || paddr[1:0] != 2'b00;
  a_reset_idle: assert property ($rose(presetn) |-> txd && rts_n && !pready && !pslverr)
    else $error("outputs not idle after reset");
  a_quiet_start: assert property ($rose(presetn) |-> (!irq && !tx_drq && !rx_drq) [*3])
    else $error("request raised before any write");
  a_ready_early: assert property ($rose(presetn) |=> pready)
    else $error("pready late after reset");
  a_ready_holds: assert property (pready |=> pready)
    else $error("pready dropped");
  a_access_ready: assert property (acc |-> pready)
    else $error("access phase without pready");
  a_err_unmapped: assert property (acc && bad |-> pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (acc && !bad |-> !pslverr)
    else $error("mapped access flagged");
  // Read data may only move after a read setup cycle
  a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
endmodule
bind ufc_uart ufc_uart_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .rxd, .cts_n, .txd, .rts_n, .irq, .tx_drq, .rx_drq);
`default_nettype wire

//--- verification/ufc_remote.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Remote serial device, no parity, one stop bit
module ufc_remote #(parameter int BIT_NS = 180) (
  input  wire logic       txd,
  input  wire logic [3:0] nbits,
  input  wire logic       hold_off,
  output var  logic       rxd,
  output var  logic       cts_n,
  output var  logic [7:0] got,
  output var  int         n_got
);
  // Line idles at mark, the level a pull-up would give
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    n_got = 0;
  end
  // Clear to send simply mirrors the bench's stall request
  always_comb cts_n = hold_off;
  // Samples mid-bit; a late start edge would shift every bit
  always begin
    @(negedge txd);
    #(BIT_NS * 3 / 2);
    got = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      got[i] = txd;
      #(BIT_NS);
    end
    n_got++;
  end
  // Sends one character on the receive line
  // Starts off the clock edge so the synchroniser never races the line
  task automatic send(input logic [7:0] b);
    #5;
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < nbits; i++) begin
      rxd = b[i];
      #(BIT_NS);
    end
    rxd = 1'b1;
    #(BIT_NS);
  endtask
endmodule
`default_nettype wire

//--- verification/tb_uart_with_fifo_flow_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "ufc_defines.vh"
// ============================================================
// Bench for the serial block with flow control
module tb_uart_with_fifo_flow_control;
  localparam logic [31:0] BASE = 32'hc0c08003; // Both paths and queues, eight bits
  localparam logic [31:0] DIV  = 32'h00000008; // Nine clocks a bit, under six megabits
  localparam int          BITC = 9;
  logic        pclk, presetn, psel, penable, pwrite, hold_off, err;
  logic [4:0]  paddr;
  logic [31:0] pwdata, rdv;
  logic [3:0]  nbits;
  logic [7:0]  got;
  int          n_got, n_errors, n_tests;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, rxd, cts_n, txd, rts_n, irq, tx_drq, rx_drq;
  ufc_uart dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .cts_n, .txd, .rts_n, .irq, .tx_drq, .rx_drq);
  ufc_remote #(.BIT_NS(BITC * 20)) rem_u (.txd, .nbits, .hold_off, .rxd, .cts_n, .got, .n_got);
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ============================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // One transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wait_frame(input int n0);
    int k;
    for (k = 0; k < 600 && n_got == n0; k++) @(posedge pclk);
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, `UFC_OFF_CTL, 32'h0);
    chk("ctl reset", `UFC_RST_CTL, rdv);
    wr(`UFC_OFF_CTL, 32'hffffffff);
    apb(1'b0, `UFC_OFF_CTL, 32'h0);
    chk("ctl bits", `UFC_CTL_MASK, rdv);
    apb(1'b0, 5'h1c, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    wr(`UFC_OFF_CTL, 32'h0);
    wr(`UFC_OFF_BR, DIV);
    $display("t_regs done");
  endtask
  task automatic t_widths();
    int w;
    int n0;
    for (w = 0; w < 4; w++) begin
      nbits <= 4'(5 + w);
      wr(`UFC_OFF_CTL, BASE & ~32'h3 | 32'(w));
      n0 = n_got;
      wr(`UFC_OFF_TXD, 32'hb6);
      wait_frame(n0);
      chk("tx char", 32'hb6 & ((32'h1 << (5 + w)) - 32'h1), 32'(got));
    end
    $display("t_widths done");
  endtask
  // Two zero bytes back to back; the high span between them is the stop time
  task automatic t_stops();
    int s;
    int k;
    for (s = 0; s < 2; s++) begin
      wr(`UFC_OFF_CTL, BASE | (32'(s) << 2));
      wr(`UFC_OFF_TXD, 32'h00);
      wr(`UFC_OFF_TXD, 32'h00);
      @(posedge txd);
      for (k = 0; k < 100 && txd === 1'b1; k++) @(posedge pclk);
      chk("stop span", 32'h1, 32'(k > BITC * (s + 1) && k <= BITC * (s + 2)));
      repeat (120) @(posedge pclk);
    end
    $display("t_stops done");
  endtask
  // A character must wait while held off, then still go out
  task automatic t_hold(input logic [31:0] c, input logic h);
    int n0;
    hold_off <= h;
    wr(`UFC_OFF_CTL, c);
    n0 = n_got;
    wr(`UFC_OFF_TXD, 32'h3c);
    repeat (300) @(posedge pclk);
    chk("held frames", 32'(n0), 32'(n_got));
    hold_off <= 1'b0;
    wr(`UFC_OFF_CTL, BASE);
    wait_frame(n0);
    chk("released char", 32'h3c, 32'(got));
    $display("t_hold done");
  endtask
  task automatic t_rts();
    int i;
    logic [31:0] c [3] = '{BASE, BASE | 32'h2000, BASE | 32'h3000};
    for (i = 0; i < 3; i++) begin
      wr(`UFC_OFF_CTL, c[i]);
      repeat (2) @(posedge pclk);
      chk("rts_n", 32'(i == 1), 32'(rts_n));
    end
    $display("t_rts done");
  endtask
  task automatic t_rx();
    int k;
    wr(`UFC_OFF_IMASK, 32'h2);
    wr(`UFC_OFF_CTL, BASE | 32'h70000);
    rem_u.send(8'h5a);
    for (k = 0; k < 60 && irq !== 1'b1; k++) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    chk("rx_drq", 32'h1, 32'(rx_drq));
    chk("tx_drq", 32'h1, 32'(tx_drq));
    apb(1'b0, `UFC_OFF_RXD, 32'h0);
    chk("rx char", 32'h5a, rdv & 32'hff);
    apb(1'b0, `UFC_OFF_DMACNT, 32'h0);
    chk("dma count", 32'h1, rdv & 32'hffff);
    wr(`UFC_OFF_STA, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(`UFC_OFF_IMASK, 32'h0);
    rem_u.send(8'ha3);
    repeat (60) @(posedge pclk);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b0, `UFC_OFF_RXD, 32'h0);
    chk("rx char", 32'ha3, rdv & 32'hff);
    $display("t_rx done");
  endtask
  // The bench sends exactly fourteen bytes; the request is withdrawn at fourteen held bytes
  task automatic t_fill();
    int i;
    wr(`UFC_OFF_CTL, BASE | 32'h1000);
    for (i = 0; i < 14; i++) rem_u.send(8'(i + 8'h30));
    repeat (20) @(posedge pclk);
    chk("rts_n full", 32'h1, 32'(rts_n));
    for (i = 0; i < 14; i++) begin
      apb(1'b0, `UFC_OFF_RXD, 32'h0);
      chk("rx order", 32'(i + 8'h30), rdv & 32'hff);
    end
    repeat (2) @(posedge pclk);
    chk("rts_n drained", 32'h0, 32'(rts_n));
    $display("t_fill done");
  endtask
  task automatic t_loop();
    hold_off <= 1'b1;
    wr(`UFC_OFF_CTL, BASE | 32'h101000);
    wr(`UFC_OFF_TXD, 32'h81);
    repeat (200) @(posedge pclk);
    apb(1'b0, `UFC_OFF_RXD, 32'h0);
    chk("loop char", 32'h81, rdv & 32'hff);
    hold_off <= 1'b0;
    $display("t_loop done");
  endtask
  // ============================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, hold_off, paddr, pwdata} = '0;
    nbits = 4'h8;
    n_errors = 0;
    n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_widths();
    t_stops();
    t_hold(BASE | 32'h80, 1'b1);
    t_hold(BASE | 32'h1000, 1'b1);
    t_hold(BASE & ~32'h40000000, 1'b0);
    t_rts();
    t_rx();
    t_fill();
    t_loop();
    end_sim();
  end
  // Watchdog, about ten times the expected run
  initial begin
    #1000000;
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    end_sim();
  end
endmodule
`default_nettype wire
